// ### design/ripple_chain.sv
// Purpose: eight stage binary chain stepped by timebase falls
// Assumes: tick is a one cycle pulse per falling timebase edge
// Notes:   stages count down so the last stage clears after 128
`timescale 1ns/1ps
module ripple_chain
  import timer_pkg::*;
(
  input  wire logic   core_clk_in, // system clock
  input  wire logic   srst_in,     // synchronous reset
  stage_chain_if.chain chain_if    // commands in, stages out
);

  logic [7:0] stage_ff; // stage flops
  logic [7:0] step;     // per stage toggle enable

  // a stage flips when every lower stage has wrapped through zero
  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_stage
      if (gi == 0) begin : g_first
        assign step[gi] = chain_if.tick; // [RULE11]
      end else begin : g_next
        assign step[gi] = step[gi-1] & ~stage_ff[gi-1]; // [RULE11]
      end
    end
  endgenerate

  // stage update: clear, set all, or ripple step
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      stage_ff <= CHAIN_CLEAR;
    end else if (chain_if.clear) begin
      stage_ff <= CHAIN_CLEAR; // [RULE12]
    end else if (chain_if.load) begin
      stage_ff <= CHAIN_SET; // [RULE3] [RULE4]
    end else begin
      stage_ff <= stage_ff ^ step; // [RULE10]
    end
  end

  assign chain_if.stages = stage_ff;

endmodule

// ### design/triggered_eight_stage_timer.sv
// Purpose: triggered long range timer with fixed eight stage chain
// Assumes: pins are asynchronous and pass a three flop conditioner
// Notes:   timebase pin is split into in, out and output enable
// Operation
// RULE1: power-up reset leaves the timer idle
// RULE2: reset high with trigger low forces reset
// RULE3: trigger rise starts: discharge, flip stages, outputs low
// RULE4: last stage output rises after 128 falls
// RULE5: trigger outranks reset when both high
// RULE6: last output fed to reset ends one-shot
// RULE7: grounded timing node stops oscillator, external clocks
// RULE8: both divided outputs driven high and low
// RULE9: external clock must be full swing square
// RULE10: fixed eight stage chain, divide two and 256
// RULE11: first stage toggles per fall, rest ripple
// RULE12: reset holds stages clear, outputs high, discharge off
`timescale 1ns/1ps
module triggered_eight_stage_timer
  import timer_pkg::*;
#(
  parameter int unsigned OSC_HALF_P = OSC_HALF // oscillator half period
)(
  input  wire logic core_clk_in,     // 20 MHz system clock
  input  wire logic srst_in,         // synchronous reset, high
  input  wire logic trigger_in,      // trigger pin
  input  wire logic reset_in,        // reset pin
  input  wire logic timing_node_gnd_in, // timing node tied low
  input  wire logic time_base_in,    // timebase pin level
  output logic      time_base_out,   // timebase pin drive value
  output logic      time_base_oe_out, // timebase pin drive enable
  output logic      discharge_out,   // discharge control
  output logic      div2_out,        // first stage, inverted
  output logic      div256_out       // last stage, inverted
);

  // ---- pin conditioning
  logic [PIN_COUNT-1:0] pins;          // raw pin levels
  logic [PIN_COUNT-1:0] sync1_ff;      // first flop, read by second only
  logic [PIN_COUNT-1:0] sync2_ff;      // second flop
  logic [PIN_COUNT-1:0] sync3_ff;      // third flop
  logic [PIN_COUNT-1:0] lvl_ff;        // accepted pin levels
  logic [PIN_COUNT-1:0] nxt_lvl;       // next accepted levels
  logic                 trig_prev_ff;  // trigger level one cycle back

  assign pins = {timing_node_gnd_in, time_base_in, reset_in, trigger_in};

  // three flop chain on every pin
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a level is taken once second and third flop agree
  genvar gp;
  generate
    for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
      assign nxt_lvl[gp] = (sync2_ff[gp] == sync3_ff[gp]) ?
                           sync2_ff[gp] : lvl_ff[gp];
    end
  endgenerate

  // accepted level register and trigger history
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      lvl_ff       <= '0;
      trig_prev_ff <= 1'b0;
    end else begin
      lvl_ff       <= nxt_lvl;
      trig_prev_ff <= lvl_ff[PIN_TRIG];
    end
  end

  logic trig_lvl;   // trigger held high
  logic trig_rise;  // trigger rising edge
  logic rst_req;    // reset asked and not overridden
  logic inhibit;    // internal oscillator stopped

  assign trig_lvl  = lvl_ff[PIN_TRIG];
  assign trig_rise = trig_lvl & ~trig_prev_ff;
  assign rst_req   = lvl_ff[PIN_RST] & ~trig_lvl; // [RULE2] [RULE5]
  assign inhibit   = lvl_ff[PIN_GND]; // [RULE7]

  // ---- control state
  timer_state_e state_ff;   // idle or running
  timer_state_e nxt_state;  // next state
  logic         start;      // start of a timing cycle

  assign start = (state_ff == ST_IDLE) & trig_rise; // [RULE3]

  // next state: trigger starts, unopposed reset stops
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_RUN; // [RULE3]
        end
      end
      ST_RUN: begin
        if (rst_req) begin
          nxt_state = ST_IDLE; // [RULE2] [RULE6]
        end
      end
    endcase
  end

  // state register, power-up lands in idle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_ff <= ST_IDLE; // [RULE1]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---- internal oscillator
  logic [15:0] osc_cnt_ff; // half period divider
  logic        osc_ff;     // oscillator level
  logic        disch_ff;   // discharge pulse

  // divider restarts on discharge, held clear while inhibited
  always_ff @(posedge core_clk_in) begin
    if (srst_in || inhibit || disch_ff) begin
      osc_cnt_ff <= OSC_CLEAR; // [RULE7]
      osc_ff     <= 1'b1;
    end else if (osc_cnt_ff == 16'(OSC_HALF_P - 1)) begin
      osc_cnt_ff <= OSC_CLEAR;
      osc_ff     <= ~osc_ff;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 16'h0001;
    end
  end

  // discharge turns on for one cycle at a start
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      disch_ff <= DISCH_RESET; // [RULE12]
    end else begin
      disch_ff <= start; // [RULE3]
    end
  end

  // ---- timebase edge detection
  logic base_src;     // chosen timebase level
  logic base_prev_ff; // timebase one cycle back
  logic base_fall;    // falling timebase edge

  // external pin clocks the chain when the node is grounded
  assign base_src  = inhibit ? lvl_ff[PIN_BASE] : osc_ff; // [RULE7] [RULE9]
  assign base_fall = base_prev_ff & ~base_src;

  // timebase history
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      base_prev_ff <= 1'b1;
    end else begin
      base_prev_ff <= base_src;
    end
  end

  // ---- counter chain
  stage_chain_if chain_if ();

  // idle clears the chain and ignores edges
  assign chain_if.clear = (state_ff == ST_IDLE) & ~start; // [RULE12]
  assign chain_if.load  = start; // [RULE3]
  assign chain_if.tick  = (state_ff == ST_RUN) & base_fall; // [RULE11]

  ripple_chain u_chain (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .chain_if    (chain_if)
  );

  // ---- outputs
  // push-pull inverted stage outputs, both levels driven
  assign div2_out   = ~chain_if.stages[0];         // [RULE8] [RULE10]
  assign div256_out = ~chain_if.stages[STAGES-1];  // [RULE8] [RULE10]
  assign discharge_out = disch_ff;

  // timebase pin driven only while the oscillator runs
  assign time_base_out    = osc_ff;
  assign time_base_oe_out = ~inhibit; // [RULE7]

  // ---- checks
  logic [7:0] fall_cnt_ff; // falls counted since the last start

  // helper count of ticks since start
  always_ff @(posedge core_clk_in) begin
    if (srst_in || start) begin
      fall_cnt_ff <= 8'h00;
    end else if (chain_if.tick) begin
      fall_cnt_ff <= fall_cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  power_up_idle_a: assert property ( // [RULE1]
    $fell(srst_in) |-> state_ff == ST_IDLE && chain_if.stages == CHAIN_CLEAR)
    else $error("not idle after power-up reset");

  reset_forces_a: assert property ( // [RULE2]
    state_ff == ST_RUN && lvl_ff[PIN_RST] && !trig_lvl
      |=> state_ff == ST_IDLE
      ##1 ($past(start) || (div256_out && div2_out)))
    else $error("reset did not return timer to idle");

  trig_start_a: assert property ( // [RULE3]
    start |=> state_ff == ST_RUN && discharge_out && !div2_out
      && !div256_out)
    else $error("trigger did not start the cycle");

  eighth_rise_a: assert property ( // [RULE4]
    state_ff == ST_RUN && $rose(div256_out) |-> fall_cnt_ff == 8'h80)
    else $error("last stage rose at wrong count");

  trig_wins_a: assert property ( // [RULE5]
    state_ff == ST_RUN && trig_lvl |=> state_ff == ST_RUN)
    else $error("reset beat a held trigger");

  one_shot_end_a: assert property ( // [RULE6]
    state_ff == ST_RUN && div256_out && lvl_ff[PIN_RST] && !trig_lvl
      |=> state_ff == ST_IDLE)
    else $error("one-shot did not end");

  inhibit_pin_a: assert property ( // [RULE7]
    inhibit |-> !time_base_oe_out ##1 osc_cnt_ff == OSC_CLEAR)
    else $error("oscillator drives while inhibited");

  first_toggle_a: assert property ( // [RULE11]
    state_ff == ST_RUN && base_fall && !rst_req |=> $changed(div2_out))
    else $error("first stage missed a fall");

  idle_hold_a: assert property ( // [RULE12]
    state_ff == ST_IDLE && $past(state_ff) == ST_IDLE && !$past(start)
      |-> div2_out && div256_out && !discharge_out)
    else $error("idle outputs not at rest");

  start_cov_c: cover property (start ##[1:20] base_fall);
  full_cycle_c: cover property (state_ff == ST_RUN && $rose(div256_out));
  ext_clock_c: cover property (inhibit && chain_if.tick);

endmodule

// ### shared/stage_chain_if.sv
// Purpose: carries commands and stage values to the ripple chain
// Assumes: single clock domain, load and tick are one cycle pulses, clear is held through idle
// Notes:   clear outranks load, load outranks tick
`timescale 1ns/1ps
interface stage_chain_if;
  logic       clear;   // hold all stages cleared
  logic       load;    // flip every stage from clear to set
  logic       tick;    // one falling timebase edge
  logic [7:0] stages;  // stage values, true sense

  modport ctrl  (output clear, output load, output tick, input stages);
  modport chain (input clear, input load, input tick, output stages);
endinterface

// ### shared/timer_pkg.sv
// Purpose: shared constants for the triggered eight stage timer
// Assumes: one 20 MHz clock, synchronous active high reset
// Notes:   counter stages are held true, pins show them inverted
package timer_pkg;

  // counter shape
  localparam int unsigned STAGES      = 8;     // fixed chain length
  localparam int unsigned HALF_COUNT  = 128;   // edges to last output rise

  // counter values
  localparam logic [7:0]  CHAIN_CLEAR = 8'h00; // value held in reset
  localparam logic [7:0]  CHAIN_SET   = 8'hff; // value after a trigger

  // pin input conditioning
  localparam int unsigned SYNC_DEPTH  = 3;     // flops per pin input
  localparam int unsigned PIN_COUNT   = 4;     // conditioned pin inputs
  localparam int unsigned PIN_TRIG    = 0;     // trigger pin slot
  localparam int unsigned PIN_RST     = 1;     // reset pin slot
  localparam int unsigned PIN_BASE    = 2;     // timebase pin slot
  localparam int unsigned PIN_GND     = 3;     // timing node grounded

  // internal oscillator
  localparam int unsigned OSC_HALF    = 16;    // clocks per half period
  localparam logic [15:0] OSC_CLEAR   = 16'h0000; // divider reset value

  // discharge pulse after a start
  localparam logic        DISCH_RESET = 1'b0;  // discharge off in reset

  // control states, gray along idle to run
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } timer_state_e;

endpackage

// ### tb/test_triggered_eight_stage_timer.sv
// Purpose: scenario bench for the triggered eight stage timer
// Assumes: inputs driven at falling clock edges
// Notes:   short oscillator half period keeps runs brief
`timescale 1ns/1ps
module test_triggered_eight_stage_timer;
  import timer_pkg::*;
  logic core_clk_in = 1'b0; // 50 ns clock
  logic srst_in = 1'b1;     // bench reset
  logic trigger_in = 1'b0;  // trigger pin
  logic rst_pin = 1'b0;     // reset pin source
  logic one_shot = 1'b0;    // feed last output to reset
  logic gnd_in = 1'b0;      // timing node grounded
  logic ext_run = 1'b0;     // external clock running
  logic reset_in, base_pin, base_out, base_oe, disch, div2, div256;
  int   error_cnt = 0, n_tests = 0, cycles = 0, n;
  assign reset_in = one_shot ? div256 : rst_pin;
  triggered_eight_stage_timer #(.OSC_HALF_P(2))
    triggered_eight_stage_timer_inst (
    .core_clk_in(core_clk_in), .srst_in(srst_in),
    .trigger_in(trigger_in), .reset_in(reset_in),
    .timing_node_gnd_in(gnd_in), .time_base_in(base_pin),
    .time_base_out(base_out), .time_base_oe_out(base_oe),
    .discharge_out(disch), .div2_out(div2), .div256_out(div256));
  timebase_source #(.HALF(3)) timebase_source_inst (
    .core_clk_in(core_clk_in), .run_in(ext_run),
    .drive_oe_in(base_oe), .drive_val_in(base_out), .pin_out(base_pin));
  // clock and hang guard
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask
  // raise trigger, wait for the start pulse
  task automatic start_cycle();
    int i;
    trigger_in = 1'b1;
    for (i = 0; i < 12 && disch !== 1'b1; i++) idle(1);
    check({6'h0, div2, div256}, 8'h00);
    check({7'h0, disch}, 8'h01);
    idle(1);
    check({7'h0, disch}, 8'h00);
  endtask
  // count first stage changes from level p0 until last stage reaches lvl
  task automatic count_to(input logic lvl, input logic p0, output int c);
    int i;
    logic prev;
    c = 0;
    prev = p0;
    for (i = 0; i < 3000 && div256 !== lvl; i++) begin
      idle(1);
      if (div2 !== prev) c++;
      prev = div2;
    end
  endtask
  // count first stage changes over k cycles
  task automatic quiet(input int k, output int c);
    logic prev;
    c = 0;
    prev = div2;
    repeat (k) begin
      idle(1);
      if (div2 !== prev) c++;
      prev = div2;
    end
  endtask
  task automatic t_power_up();
    logic p;
    check({5'h0, div2, div256, disch}, 8'h06);
    quiet(40, n);
    check(8'(n), 8'h00);
    p = base_out;
    idle(2);
    check({6'h0, base_oe, base_out ^ p}, 8'h03);
  endtask
  task automatic t_astable();
    start_cycle();
    trigger_in = 1'b0;
    count_to(1'b1, 1'b0, n);
    check(8'(n), 8'h80);
    count_to(1'b0, div2, n);
    check(8'(n), 8'h80);
  endtask
  task automatic t_reset_run();
    rst_pin = 1'b1;
    idle(10);
    check({5'h0, div2, div256, disch}, 8'h06);
    quiet(20, n);
    check(8'(n), 8'h00);
    rst_pin = 1'b0;
  endtask
  task automatic t_priority();
    idle(4);
    rst_pin = 1'b1;
    start_cycle();
    idle(30);
    check({7'h0, div256}, 8'h00);
    trigger_in = 1'b0;
    idle(10);
    check({6'h0, div2, div256}, 8'h03);
    rst_pin = 1'b0;
  endtask
  task automatic t_one_shot();
    one_shot = 1'b1;
    idle(8);
    start_cycle();
    trigger_in = 1'b0;
    count_to(1'b1, 1'b0, n);
    check(8'(n), 8'h80);
    idle(15);
    quiet(40, n);
    check({6'h0, div2, div256}, 8'h03);
    check(8'(n), 8'h00);
    one_shot = 1'b0;
  endtask
  task automatic t_external();
    gnd_in = 1'b1;
    ext_run = 1'b1;
    idle(8);
    check({7'h0, base_oe}, 8'h00);
    start_cycle();
    trigger_in = 1'b0;
    count_to(1'b1, 1'b0, n);
    check(8'(n), 8'h80);
    t_reset_run();
    ext_run = 1'b0;
  endtask
  // main sequence
  initial begin
    idle(20);
    srst_in = 1'b0;
    idle(8);
    t_power_up();
    t_astable();
    t_reset_run();
    t_priority();
    t_one_shot();
    t_external();
    complete_run();
  end
endmodule

// ### tb/timebase_source.sv
// Purpose: external square wave clock on the timebase pin
// Assumes: design releases the pin while its timing node is grounded
// Notes:   stopped source parks its line high, still driven
`timescale 1ns/1ps
module timebase_source #(
  parameter int HALF = 3 // clocks per half period
)(
  input  wire logic core_clk_in,  // system clock
  input  wire logic run_in,       // source running
  input  wire logic drive_oe_in,  // design drives the pin
  input  wire logic drive_val_in, // design drive value
  output logic      pin_out       // resolved pin level
);
  logic lvl = 1'b1; // source line level
  int   cnt = 0;    // half period counter
  // full swing, even duty square wave
  always @(negedge core_clk_in) begin
    if (!run_in) begin
      lvl = 1'b1;
      cnt = 0;
    end else if (cnt == HALF - 1) begin
      lvl = ~lvl;
      cnt = 0;
    end else begin
      cnt++;
    end
  end
  // design drive wins while enabled
  assign pin_out = drive_oe_in ? drive_val_in : lvl;
endmodule
